//--- rtl/mbicm_top.sv
// Behaviour
// - 32-bit values travel low word first
// - two written words reassemble low word first
// - long and float are word swapped
// - float ieee single, integer 16 bits, bool bit
// - answer unit 1 unless reconfigured
// - reads served once address is configured
// - write commands accepted only in tcp mode
// - factory ip, mask and gateway defaults
// - auto addressing needs flash store and power cycle
// - auto addressing failure shows an error status
// - function 01 packs contiguous coils bitwise
// - coils 100..107 mirror inputs 1..8
// - integrated variant refuses coil read
// - invalid requests may get no reply
`timescale 1ns/100ps
`default_nettype none
module mbicm_top import mbicm_pkg::*; (
   input  wire logic                  i_mclk,          // 50 MHz clock
   input  wire logic                  i_reset_n,       // sync reset, active low
   input  wire logic                  i_ce,            // clock enable
   input  wire logic [COIL_COUNT-1:0] i_din,           // digital inputs 1..8
   input  wire logic                  i_req_valid,     // parsed request strobe
   input  wire logic [7:0]            i_req_unit,      // request unit number
   input  wire logic [7:0]            i_req_func,      // request function code
   input  wire logic [15:0]           i_req_addr,      // start address
   input  wire logic [15:0]           i_req_qty,       // quantity
   input  wire logic                  i_variant_integ, // integrated tcp variant
   input  wire logic                  i_mode_tcp,      // operating mode is modbus tcp
   input  wire logic                  i_cfg_valid,     // config word strobe
   input  wire logic                  i_cfg_low,       // config word is low half
   input  wire logic [1:0]            i_cfg_sel,       // config target
   input  wire logic [15:0]           i_cfg_word,      // config word
   input  wire logic                  i_flash_dhcp_en, // stored auto addressing setting
   input  wire logic                  i_dhcp_bound,    // lease obtained, pulse
   input  wire logic                  i_dhcp_fail,     // lease failed, pulse
   input  wire logic [31:0]           i_dhcp_ip,       // leased address
   output logic                       o_rsp_valid,     // answer pulse
   output logic                       o_rsp_exc,       // answer is an exception
   output logic      [7:0]            o_rsp_code,      // function or exception code
   output logic      [COIL_COUNT-1:0] o_rsp_bits,      // packed coil states
   output logic                       o_fwd_valid,     // request passed on, pulse
   output logic      [7:0]            o_fwd_func,      // passed function code
   output logic      [31:0]           o_ip_addr,       // active ip address
   output logic      [31:0]           o_net_mask,      // subnet mask
   output logic      [31:0]           o_gateway,       // default gateway
   output logic      [7:0]            o_unit_id,       // unit number in use
   output logic                       o_dhcp_active,   // auto addressing in force
   output logic                       o_dhcp_err,      // auto addressing failed
   output logic                       o_net_ready      // address usable
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   function automatic logic is_write(input logic [7:0] f);
      return f == FC_WRITE_COIL || f == FC_WRITE_REG || f == FC_WRITE_COILS ||
             f == FC_WRITE_REGS;
   endfunction

   function automatic logic hits_coils(input logic [15:0] a, input logic [15:0] q);
      return a >= INPUT_LINE_1_STATE_OFS && a <= INPUT_LINE_8_STATE_OFS &&
             ({1'b0, a} + {1'b0, q}) <= {1'b0, COIL_END};
   endfunction

   logic        join_valid;
   logic [31:0] join_value;
   logic [1:0]  sel_r;
   logic        captured_r;
   logic        bound_r;
   logic        take;
   logic        own_unit;
   logic        read_ok;
   logic        coil_write;
   logic        pack_load;
   logic        is_read_coils;

   assign take          = i_ce && i_req_valid;
   assign own_unit      = i_req_unit == o_unit_id;
   assign is_read_coils = i_req_func == FC_READ_COILS;
   assign read_ok       = i_req_qty != 16'h0000 && i_req_qty <= 16'h0008;
   assign coil_write    = (i_req_func == FC_WRITE_COIL || i_req_func == FC_WRITE_COILS) &&
                          hits_coils(i_req_addr, (i_req_func == FC_WRITE_COIL) ?
                                     16'h0001 : i_req_qty);
   assign pack_load     = take && own_unit && o_net_ready && is_read_coils && !i_variant_integ
                          && read_ok && hits_coils(i_req_addr, i_req_qty);

   // config words: low half first, then high half completes the value
   mbicm_word_join u_join (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_ce      (i_ce),
      .i_valid   (i_cfg_valid),
      .i_low     (i_cfg_low),
      .i_word    (i_cfg_word),
      .o_valid   (join_valid),
      .o_value   (join_value)
   );

   mbicm_coil_pack u_pack (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_ce      (i_ce),
      .i_load    (pack_load),
      .i_lines   (i_din),
      .i_first   (3'(i_req_addr - INPUT_LINE_1_STATE_OFS)),
      .i_qty     (i_req_qty[3:0]),
      .o_bits    (o_rsp_bits)
   );

   // the selector travels with the low word
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         sel_r <= CFG_SEL_IP;
      end else if (i_ce && i_cfg_valid && i_cfg_low) begin
         sel_r <= i_cfg_sel;
      end
   end

   // manual network settings; a leased address overrides only the ip
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_ip_addr  <= IP_DEFAULT;
         o_net_mask <= MASK_DEFAULT;
         o_gateway  <= GATEWAY_DEFAULT;
         o_unit_id  <= UNIT_DEFAULT;
      end else if (i_ce) begin
         if (o_dhcp_active && i_dhcp_bound) begin
            o_ip_addr <= i_dhcp_ip;
         end else if (join_valid && sel_r == CFG_SEL_IP && !o_dhcp_active) begin
            o_ip_addr <= join_value;
         end
         if (join_valid && sel_r == CFG_SEL_MASK) begin
            o_net_mask <= join_value;
         end
         if (join_valid && sel_r == CFG_SEL_GATEWAY) begin
            o_gateway <= join_value;
         end
         if (join_valid && sel_r == CFG_SEL_UNIT) begin
            o_unit_id <= join_value[7:0];
         end
      end
   end

   // the stored setting is sampled once after reset, so a change in flash
   // only counts after the next power cycle
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         captured_r    <= 1'b0;
         o_dhcp_active <= 1'b0;
      end else if (i_ce && !captured_r) begin
         captured_r    <= 1'b1;
         o_dhcp_active <= i_flash_dhcp_en;
      end
   end

   // failure flag: a new failure beats a clearing lease in the same cycle
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_dhcp_err <= 1'b0;
         bound_r    <= 1'b0;
      end else if (i_ce && o_dhcp_active) begin
         if (i_dhcp_fail) begin
            o_dhcp_err <= 1'b1;
            bound_r    <= 1'b0;
         end else if (i_dhcp_bound) begin
            o_dhcp_err <= 1'b0;
            bound_r    <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_net_ready <= 1'b0;
      end else if (i_ce) begin
         o_net_ready <= captured_r && (!o_dhcp_active || bound_r);
      end
   end

   // answers for the coil map; other codes are passed to the command side, except coil writes within the input coils and writes outside tcp mode
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_rsp_valid <= 1'b0;
         o_rsp_exc   <= 1'b0;
         o_rsp_code  <= 8'h00;
      end else if (i_ce) begin
         o_rsp_valid <= 1'b0;
         if (take && own_unit && o_net_ready && is_read_coils) begin
            if (i_variant_integ) begin
               o_rsp_valid <= 1'b1;
               o_rsp_exc   <= 1'b1;
               o_rsp_code  <= EXC_ILLEGAL_FUNC;
            end else if (!read_ok) begin
               o_rsp_valid <= 1'b0;
            end else if (hits_coils(i_req_addr, i_req_qty)) begin
               o_rsp_valid <= 1'b1;
               o_rsp_exc   <= 1'b0;
               o_rsp_code  <= FC_READ_COILS;
            end else begin
               o_rsp_valid <= 1'b1;
               o_rsp_exc   <= 1'b1;
               o_rsp_code  <= EXC_ILLEGAL_ADDR;
            end
         end
      end
   end

   // a coil write lying wholly within the input coils is dropped silently: nothing here is
   // writable, and passing it on could let the command side alias the inputs
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_fwd_valid <= 1'b0;
         o_fwd_func  <= 8'h00;
      end else if (i_ce) begin
         o_fwd_valid <= 1'b0;
         if (take && own_unit && o_net_ready && !is_read_coils && !coil_write &&
             (!is_write(i_req_func) || i_mode_tcp)) begin
            o_fwd_valid <= 1'b1;
            o_fwd_func  <= i_req_func;
         end
      end
   end

   unit_default_a: assert property ($rose(i_reset_n) |-> o_unit_id == 8'h01)
      else $error("unit number not 1 after reset");
   net_default_a: assert property ($rose(i_reset_n) |->
      o_ip_addr == 32'hc0a80064 && o_net_mask == 32'hffffff00 && o_gateway == 32'hc0a80001)
      else $error("network defaults wrong after reset");
   foreign_unit_a: assert property (take && !own_unit |=> !o_rsp_valid && !o_fwd_valid)
      else $error("answered another unit");
   not_ready_a: assert property (take && !o_net_ready |=> !o_rsp_valid && !o_fwd_valid)
      else $error("served before address configured");
   tcp_gate_a: assert property (o_fwd_valid && is_write(o_fwd_func) |-> $past(i_mode_tcp))
      else $error("command accepted outside tcp mode");
   integ_refuse_a: assert property (take && own_unit && o_net_ready && is_read_coils &&
      i_variant_integ |=> o_rsp_valid && o_rsp_exc && o_rsp_code == 8'h01)
      else $error("integrated variant served coil read");
   coil_map_a: assert property (pack_load && i_req_addr == 16'h0064 && i_req_qty == 16'h0008
      |=> o_rsp_valid && !o_rsp_exc && o_rsp_bits == $past(i_din))
      else $error("coil map does not mirror inputs");
   single_coil_a: assert property (pack_load && i_req_qty == 16'h0001 |=>
      o_rsp_bits == {7'h00, $past(i_din[i_req_addr[2:0] - 3'h4])})
      else $error("single coil read wrong");
   empty_qty_a: assert property (take && i_req_qty == 16'h0000 && is_read_coils |=>
      !o_rsp_valid) else $error("reply to zero quantity");
   coil_write_a: assert property (take && coil_write |=> !o_fwd_valid && !o_rsp_valid)
      else $error("coil write not dropped");
   dhcp_err_a: assert property (i_ce && o_dhcp_active && i_dhcp_fail |=> o_dhcp_err)
      else $error("auto addressing failure lost");
   dhcp_latch_a: assert property (captured_r && i_ce |=> $stable(o_dhcp_active))
      else $error("auto addressing changed without power cycle");

   read_cov_c:  cover property (pack_load ##1 o_rsp_valid);
   exc_cov_c:   cover property (o_rsp_valid && o_rsp_code == 8'h02);
   fwd_cov_c:   cover property (o_fwd_valid && is_write(o_fwd_func));
   dhcp_cov_c:  cover property (o_dhcp_err ##[1:20] bound_r);
endmodule // mbicm_top
`default_nettype wire

//--- rtl/mbicm_pkg.sv
package mbicm_pkg;
   // modbus function codes handled or screened here, and the exception codes sent
   localparam logic [7:0]  FC_READ_COILS    = 8'h01;
   localparam logic [7:0]  FC_WRITE_COIL    = 8'h05;
   localparam logic [7:0]  FC_WRITE_REG     = 8'h06;
   localparam logic [7:0]  FC_WRITE_COILS   = 8'h0f;
   localparam logic [7:0]  FC_WRITE_REGS    = 8'h10;
   localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
   // coil map of the digital inputs
   localparam logic [15:0] INPUT_LINE_1_STATE_OFS = 16'h0064;
   localparam logic [15:0] INPUT_LINE_2_STATE_OFS = 16'h0065;
   localparam logic [15:0] INPUT_LINE_3_STATE_OFS = 16'h0066;
   localparam logic [15:0] INPUT_LINE_4_STATE_OFS = 16'h0067;
   localparam logic [15:0] INPUT_LINE_5_STATE_OFS = 16'h0068;
   localparam logic [15:0] INPUT_LINE_6_STATE_OFS = 16'h0069;
   localparam logic [15:0] INPUT_LINE_7_STATE_OFS = 16'h006a;
   localparam logic [15:0] INPUT_LINE_8_STATE_OFS = 16'h006b;
   localparam int          COIL_COUNT             = 8;
   localparam logic [15:0] COIL_END               = 16'h006c;
   // defaults
   localparam logic [7:0]  UNIT_DEFAULT    = 8'h01;
   localparam logic [31:0] IP_DEFAULT      = 32'hc0a80064;
   localparam logic [31:0] MASK_DEFAULT    = 32'hffffff00;
   localparam logic [31:0] GATEWAY_DEFAULT = 32'hc0a80001;
   // configuration word selectors
   localparam logic [1:0]  CFG_SEL_IP      = 2'h0;
   localparam logic [1:0]  CFG_SEL_MASK    = 2'h1;
   localparam logic [1:0]  CFG_SEL_GATEWAY = 2'h2;
   localparam logic [1:0]  CFG_SEL_UNIT    = 2'h3;
endpackage

//--- rtl/mbicm_word_join.sv
`timescale 1ns/100ps
`default_nettype none
module mbicm_word_join (
   input  wire logic        i_mclk,      // system clock
   input  wire logic        i_reset_n,   // sync reset
   input  wire logic        i_ce,        // clock enable
   input  wire logic        i_valid,     // word strobe
   input  wire logic        i_low,       // word is the low half
   input  wire logic [15:0] i_word,      // 16-bit word
   output logic             o_valid,     // 32-bit value ready, one cycle
   output logic      [31:0] o_value      // joined value
);
   logic        have_low_r;
   logic [15:0] low_r;

   // low word first, high word completes the value
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         have_low_r <= 1'b0;
         low_r      <= 16'h0000;
      end else if (i_ce) begin
         if (i_valid && i_low) begin
            have_low_r <= 1'b1;
            low_r      <= i_word;
         end else if (i_valid) begin
            have_low_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_valid <= 1'b0;
         o_value <= 32'h00000000;
      end else if (i_ce) begin
         o_valid <= i_valid && !i_low && have_low_r;
         if (i_valid && !i_low && have_low_r) begin
            o_value <= {i_word, low_r};
         end
      end
   end

   join_order_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_ce && i_valid && !i_low && have_low_r |=> o_value == {$past(i_word), $past(low_r)})
      else $error("joined value not low word first");
endmodule // mbicm_word_join
`default_nettype wire

//--- rtl/mbicm_coil_pack.sv
`timescale 1ns/100ps
`default_nettype none
module mbicm_coil_pack import mbicm_pkg::*; (
   input  wire logic                  i_mclk,    // system clock
   input  wire logic                  i_reset_n, // sync reset
   input  wire logic                  i_ce,      // clock enable
   input  wire logic                  i_load,    // capture a packed answer
   input  wire logic [COIL_COUNT-1:0] i_lines,   // input states, line 1 in bit 0
   input  wire logic [2:0]            i_first,   // first coil index
   input  wire logic [3:0]            i_qty,     // coils asked for, 1..8
   output logic      [COIL_COUNT-1:0] o_bits     // packed, first coil in bit 0
);
   logic [COIL_COUNT-1:0] bits_nxt;

   // unused tail bits are zero, as the byte must be padded
   always_comb begin
      bits_nxt = '0;
      for (int k = 0; k < COIL_COUNT; k++) begin
         if (k < int'(i_qty) && (k + int'(i_first)) < COIL_COUNT) begin
            bits_nxt[k] = i_lines[k + int'(i_first)];
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_bits <= '0;
      end else if (i_ce && i_load) begin
         o_bits <= bits_nxt;
      end
   end
endmodule // mbicm_coil_pack
`default_nettype wire

//--- sim/mbicm_master.sv
`timescale 1ns/100ps
`default_nettype none
module mbicm_master (
   input  wire logic        i_mclk,      // system clock
   output logic             o_req_valid, // request strobe
   output logic      [7:0]  o_req_unit,  // unit number
   output logic      [7:0]  o_req_func,  // function code
   output logic      [15:0] o_req_addr,  // start address
   output logic      [15:0] o_req_qty,   // quantity
   output logic             o_cfg_valid, // config word strobe
   output logic             o_cfg_low,   // word is the low half
   output logic      [1:0]  o_cfg_sel,   // config target
   output logic      [15:0] o_cfg_word   // config word
);
   initial begin
      o_req_valid = 1'b0;
      o_req_unit  = 8'h00;
      o_req_func  = 8'h00;
      o_req_addr  = 16'h0000;
      o_req_qty   = 16'h0000;
      o_cfg_valid = 1'b0;
      o_cfg_low   = 1'b0;
      o_cfg_sel   = 2'h0;
      o_cfg_word  = 16'h0000;
   end
   // held until the next call or idle(); a following call makes the requests back to back
   task automatic req(input logic [7:0] unit, func, input logic [15:0] addr, qty);
      @(negedge i_mclk);
      o_req_valid = 1'b1;
      o_req_unit  = unit;
      o_req_func  = func;
      o_req_addr  = addr;
      o_req_qty   = qty;
   endtask
   // released unit, address, quantity and config word are scrambled so nothing can lean on stale values
   task automatic idle();
      @(negedge i_mclk);
      o_req_valid = 1'b0;
      o_req_unit  = ~o_req_unit;
      o_req_addr  = ~o_req_addr;
      o_req_qty   = ~o_req_qty;
      o_cfg_valid = 1'b0;
      o_cfg_word  = ~o_cfg_word;
   endtask
   // a 32-bit value is split into two 16-bit words, low word first
   task automatic cfg32(input logic [1:0] sel, input logic [31:0] value);
      @(negedge i_mclk);
      o_cfg_valid = 1'b1;
      o_cfg_low   = 1'b1;
      o_cfg_sel   = sel;
      o_cfg_word  = value[15:0];
      @(negedge i_mclk);
      o_cfg_low   = 1'b0;
      o_cfg_word  = value[31:16];
      idle();
   endtask
endmodule // mbicm_master
`default_nettype wire

//--- sim/modbus_input_coil_map_test.sv
`timescale 1ns/100ps
`default_nettype none
module modbus_input_coil_map_test import mbicm_pkg::*;;
   typedef struct packed {logic fwd; logic exc; logic [7:0] code; logic [7:0] bits;} mbicm_exp_s;
   logic        mclk, reset_n, integ, mode_tcp, flash, bound, fail;
   logic [7:0]  din, rsp_code, rsp_bits, fwd_func, unit_id;
   logic [31:0] dhcp_ip, ip_addr, net_mask, gateway;
   logic        rsp_valid, rsp_exc, fwd_valid, dhcp_active, dhcp_err, net_ready;
   logic        req_valid, cfg_valid, cfg_low;
   logic [7:0]  req_unit, req_func;
   logic [15:0] req_addr, req_qty, cfg_word;
   logic [1:0]  cfg_sel;
   mbicm_exp_s  exp_q[$];
   int          num_errors, tests_run;
   mbicm_master m_u (.i_mclk(mclk), .o_req_valid(req_valid), .o_req_unit(req_unit),
      .o_req_func(req_func), .o_req_addr(req_addr), .o_req_qty(req_qty),
      .o_cfg_valid(cfg_valid), .o_cfg_low(cfg_low), .o_cfg_sel(cfg_sel), .o_cfg_word(cfg_word));
   mbicm_top dut_u (.i_mclk(mclk), .i_reset_n(reset_n), .i_ce(1'b1), .i_din(din),
      .i_req_valid(req_valid), .i_req_unit(req_unit), .i_req_func(req_func),
      .i_req_addr(req_addr), .i_req_qty(req_qty), .i_variant_integ(integ),
      .i_mode_tcp(mode_tcp), .i_cfg_valid(cfg_valid), .i_cfg_low(cfg_low),
      .i_cfg_sel(cfg_sel), .i_cfg_word(cfg_word), .i_flash_dhcp_en(flash),
      .i_dhcp_bound(bound), .i_dhcp_fail(fail), .i_dhcp_ip(dhcp_ip),
      .o_rsp_valid(rsp_valid), .o_rsp_exc(rsp_exc), .o_rsp_code(rsp_code),
      .o_rsp_bits(rsp_bits), .o_fwd_valid(fwd_valid), .o_fwd_func(fwd_func),
      .o_ip_addr(ip_addr), .o_net_mask(net_mask), .o_gateway(gateway), .o_unit_id(unit_id),
      .o_dhcp_active(dhcp_active), .o_dhcp_err(dhcp_err), .o_net_ready(net_ready));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("tests_run %0d num_errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // wide enough for the joined compares, so no setting is cut off unseen
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rsp(input mbicm_exp_s e);
      // exc and code stand from the last answer, so a forward compares its own fields only
      if (e.fwd) chk_val({fwd_valid, rsp_valid, fwd_func}, {2'b10, e.code});
      else chk_val({fwd_valid, rsp_valid, rsp_exc, rsp_code}, {2'b01, e.exc, e.code});
      if (!e.fwd && !e.exc) chk_val(rsp_bits, e.bits);
   endtask
   // every answer pulse takes the oldest note; an answer with no note is itself a mismatch
   always @(negedge mclk) begin
      if (rsp_valid === 1'b1 || fwd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk_val({fwd_valid, rsp_valid}, 32'h0);
         else chk_rsp(exp_q.pop_front());
      end
   end
   // kind: 0 no reply, 1 normal, 2 address exception, 3 function exception
   task automatic rdc(input logic [7:0] unit, input logic [15:0] addr, qty, input int kind);
      logic [7:0] bits;
      m_u.req(unit, FC_READ_COILS, addr, qty);
      din = 8'($urandom);
      bits = 8'(din >> (addr - 16'h0064)) & 8'((16'h1 << qty) - 16'h1);
      if (kind == 1) exp_q.push_back({1'b0, 1'b0, 8'h01, bits});
      if (kind == 2) exp_q.push_back({1'b0, 1'b1, 8'h02, 8'h00});
      if (kind == 3) exp_q.push_back({1'b0, 1'b1, 8'h01, 8'h00});
   endtask
   task automatic req(input logic [7:0] func, input logic [15:0] addr, input logic fwd);
      m_u.req(8'h01, func, addr, 16'h0001);
      if (fwd) exp_q.push_back({1'b1, 1'b0, func, 8'h00});
   endtask
   task automatic drain();
      m_u.idle();
      repeat (3) @(negedge mclk);
      chk_val(32'(exp_q.size()), 32'h0);
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
   initial begin
      int f;
      int q;
      void'($urandom(32'h91a8758d));
      {reset_n, integ, flash, bound, fail} = 5'h00;
      mode_tcp = 1'b1;
      din = 8'h00;
      dhcp_ip = 32'h0;
      repeat (8) @(negedge mclk);
      reset_n = 1'b1;
      chk_val(ip_addr, 32'hc0a80064);
      chk_val({net_mask, gateway}, {32'hffffff00, 32'hc0a80001});
      chk_val(unit_id, 8'h01);
      repeat (3) @(negedge mclk);
      chk_val({dhcp_active, net_ready}, 2'b01);
      for (f = 0; f < 8; f++) begin
         rdc(8'h01, 16'(100 + f), 16'(8 - f), 1);
         rdc(8'h01, 16'(100 + f), 16'h0001, 1);
      end
      repeat (16) begin
         f = $urandom % 8;
         q = 1 + $urandom % (8 - f);
         rdc(8'h01, 16'(100 + f), 16'(q), 1);
      end
      rdc(8'h01, 16'h006b, 16'h0002, 2);
      rdc(8'h01, 16'h0063, 16'h0001, 2);
      rdc(8'h01, 16'h0064, 16'h0000, 0);
      rdc(8'h01, 16'h0064, 16'h0009, 0);
      rdc(8'h02, 16'h0064, 16'h0001, 0);
      drain();
      req(FC_WRITE_COIL, 16'h0064, 1'b0);
      req(FC_WRITE_COILS, 16'h0067, 1'b0);
      req(FC_WRITE_REG, 16'h0000, 1'b1);
      req(8'h03, 16'h0000, 1'b1);
      m_u.idle();
      mode_tcp = 1'b0;
      req(FC_WRITE_REG, 16'h0000, 1'b0);
      req(FC_WRITE_REGS, 16'h0000, 1'b0);
      req(FC_WRITE_COIL, 16'h0000, 1'b0);
      req(FC_WRITE_COILS, 16'h0000, 1'b0);
      req(8'h04, 16'h0000, 1'b1);
      m_u.idle();
      mode_tcp = 1'b1;
      integ = 1'b1;
      rdc(8'h01, 16'h0064, 16'h0008, 3);
      m_u.idle();
      integ = 1'b0;
      drain();
      m_u.cfg32(CFG_SEL_IP, 32'h12345678);
      repeat (2) @(negedge mclk);
      chk_val(ip_addr, 32'h12345678);
      m_u.cfg32(CFG_SEL_MASK, 32'hffff0000);
      repeat (2) @(negedge mclk);
      chk_val(net_mask, 32'hffff0000);
      m_u.cfg32(CFG_SEL_GATEWAY, 32'h3f800000);
      repeat (2) @(negedge mclk);
      chk_val(gateway, 32'h3f800000);
      m_u.cfg32(CFG_SEL_UNIT, 32'h00000005);
      repeat (2) @(negedge mclk);
      chk_val(unit_id, 8'h05);
      rdc(8'h05, 16'h0064, 16'h0004, 1);
      rdc(8'h01, 16'h0064, 16'h0004, 0);
      drain();
      reset_n = 1'b0;
      flash = 1'b1;
      repeat (3) @(negedge mclk);
      reset_n = 1'b1;
      chk_val({ip_addr, unit_id}, {32'hc0a80064, 8'h01});
      chk_val({net_mask, gateway}, {32'hffffff00, 32'hc0a80001});
      repeat (3) @(negedge mclk);
      chk_val({dhcp_active, net_ready}, 2'b10);
      rdc(8'h01, 16'h0064, 16'h0008, 0);
      m_u.idle();
      fail = 1'b1;
      @(negedge mclk);
      fail = 1'b0;
      @(negedge mclk);
      chk_val(dhcp_err, 1'b1);
      dhcp_ip = 32'h0a000002;
      bound = 1'b1;
      @(negedge mclk);
      bound = 1'b0;
      repeat (2) @(negedge mclk);
      chk_val({ip_addr, dhcp_err, net_ready}, {32'h0a000002, 2'b01});
      rdc(8'h01, 16'h0066, 16'h0003, 1);
      drain();
      // a manual address must not displace the leased one
      m_u.cfg32(CFG_SEL_IP, 32'h11223344);
      repeat (2) @(negedge mclk);
      chk_val(ip_addr, 32'h0a000002);
      end_of_test();
   end
endmodule // modbus_input_coil_map_test
`default_nettype wire
